/* File: logic/sem_monitor.sv */
// serial link error monitor with loopback, test modes and register file
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - one internal prbs source drives each lane whose loopback bit is set
// - half rate bit slows prbs; sync init pulse reseeds it
// - steady code groups keep sync request released, cgs bits set
// - sync released after code groups on every enabled lane
// - per-lane lane alignment passed bits are shown
// - disparity error hidden at the same position as a nit error
// - three nit errors give no disparity count with qualify set
// - three monitor enables per lane, enabled after reset
// - a set reset bit clears its counter
// - hold flag saturates at ff, otherwise the counter wraps
// - one threshold, default ff, for all types drives irq and sync
// - masked type at threshold on any lane asserts sync request
// - sticky terminal count bits per counter plus lane active bit
// - interrupt enables reset off, nine events covered
// - status bits sit at the positions of their enables
// - error pulse on sync output lasts half a pclk or one to fifteen pclk
// - mask bit 2 disparity, bit 1 nit, bit 0 unexpected
// - writing one to a status bit clears it
// - link reinit clears counts but leaves interrupt status
module sem_monitor
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [sem_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [sem_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic linkEnable,
  input wire logic linkReinit,
  input wire logic [7:0] laneEnabled,
  input wire logic [7:0] laneActive,
  input wire logic [7:0] cgsDone,
  input wire logic [7:0] ilasDone,
  input wire logic [4:0] linkFailEvent,
  input wire logic configMismatch,
  input wire logic [7:0] unexpectedControlChar,
  input wire logic [7:0] notInTable,
  input wire logic [7:0] badDisparity,
  output logic syncRequestOutN,
  output logic [7:0] loopbackData,
  output logic [7:0] loopbackLaneEnable,
  output logic loopbackHalfRate,
  output logic [15:0] equalizerGainField,
  output logic [7:0] laneInvertSelect,
  output logic ilasTestMode,
  output logic readErrorQualify
);
  import sem_pkg::*;

  // decoding shared by the read and write paths
  function automatic logic isMapped(input sem_idx_type idx);
    isMapped = (idx == IDX_POL_INV) || (idx == IDX_EQ_LO) ||
      (idx == IDX_EQ_HI) || (idx == IDX_LB_EN) || (idx == IDX_LB_CTL) ||
      (idx == IDX_LINK_PAGE) || (idx == IDX_SYNC_DUR) ||
      (idx == IDX_CGS_STAT) || (idx == IDX_ILAS_STAT) ||
      (idx == IDX_QUAL) || (idx == IDX_TEST_MODE) ||
      (idx == IDX_THRESH) || (idx == IDX_MASK) ||
      (idx >= IDX_ERR_CTRL && idx <= IDX_TERM_LAST) ||
      (idx >= IDX_IRQ_EN && idx <= IDX_IRQ_ST_MM) ||
      (idx >= IDX_COUNT && idx < IDX_COUNT + IDX_COUNT_SPAN &&
       idx[1:0] != 2'h3);
  endfunction : isMapped

  // pulse length in clk cycles from the duration field
  function automatic logic [4:0] pulseClks(input logic [3:0] dur);
    logic [8:0] prod;
    prod = 9'({5'h00, dur} * PCLK_CLKS);
    pulseClks = (dur == 4'h0) ? HALF_PCLK_CLKS : prod[4:0];
  endfunction : pulseClks

  logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
  logic awHeld_q, wHeld_q, wStrb_q;
  logic [1:0] bResp_q, rResp_q;
  logic [31:0] rData_q;
  sem_idx_type awIdx_q;
  logic [7:0] wData_q;
  logic [7:0] polInv_q, eqLo_q, eqHi_q, lbEn_q, lbCtl_q, linkPage_q;
  logic [7:0] syncDur_q, qual_q, testMode_q, thresh_q, mask_q;
  logic [7:0] errCtrl_q [LANES];
  logic [7:0] hold_q [LANES];
  logic [7:0] cgsStat_q, ilasStat_q, active_q;
  logic [7:0] irqEn_q, irqEnMm_q, irqSt_q, irqStMm_q;
  logic [2:0] thrPrev_q;
  logic [6:0] prbs_q;
  logic halfPhase_q, syncInitPrev_q;
  logic [7:0] lbData_q;
  sem_sync_state_type state_q;
  logic [4:0] pulseCnt_q;
  logic syncN_q;
  logic [23:0] laneCount [LANES];
  logic [2:0] laneTerm [LANES];
  logic [2:0] laneAtThr [LANES];
  logic doWrite, wr;
  logic [7:0] readByte;
  logic [2:0] thrAny, thrSync;
  logic errAny, cgsAll;
  sem_idx_type rIdx;

  assign doWrite = awHeld_q && wHeld_q && !bValid_q;
  assign wr = doWrite && wStrb_q && isMapped(awIdx_q);
  assign rIdx = araddr[ADDR_W-1:2];

  // per-lane counter blocks joined through the carrier interface
  genvar l;
  generate
    for (l = 0; l < LANES; l++)
    begin : g_lane
      sem_cnt_if cif ();
      assign cif.errIn[TYPE_UEK] = unexpectedControlChar[l];
      assign cif.errIn[TYPE_NIT] = notInTable[l];
      // disparity at a nit position is dropped, later ones still count
      assign cif.errIn[TYPE_BDE] = badDisparity[l] && !notInTable[l];
      assign cif.enable = errCtrl_q[l][ERR_EN_LSB +: 3];
      assign cif.clear = errCtrl_q[l][CNT_RST_LSB +: 3] | {3{linkReinit}};
      assign cif.hold = hold_q[l][2:0];
      assign cif.threshold = thresh_q;
      assign laneCount[l] = cif.count;
      assign laneTerm[l] = cif.terminal;
      assign laneAtThr[l] = cif.atThreshold;
      sem_lane_counter u_cnt (
        .clk(clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .port(cif.cnt)
      );
    end
  endgenerate

  // or-reduce threshold hits over all lanes and errors over enabled lanes
  always_comb
  begin
    thrAny = 3'h0;
    errAny = 1'b0;
    for (int i = 0; i < LANES; i++)
    begin
      thrAny = thrAny | laneAtThr[i];
      errAny = errAny || (laneEnabled[i] &&
        |(errCtrl_q[i][ERR_EN_LSB +: 3] &
          {badDisparity[i] && !notInTable[i], notInTable[i],
           unexpectedControlChar[i]}));
    end
    thrSync = thrAny & mask_q[2:0];
    cgsAll = &(cgsDone | ~laneEnabled);
  end

  // axi write channels: address and data taken in either order
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awIdx_q <= '0;
      wData_q <= ZERO_RST;
      wStrb_q <= 1'b0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (awvalid && awReady_q)
      begin
        awHeld_q <= 1'b1;
        awReady_q <= 1'b0;
        awIdx_q <= awaddr[ADDR_W-1:2];
      end
      if (wvalid && wReady_q)
      begin
        wHeld_q <= 1'b1;
        wReady_q <= 1'b0;
        wData_q <= wdata[7:0];
        wStrb_q <= wstrb[0]; // upper lanes hold no bits
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= isMapped(awIdx_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bValid_q && bready)
      begin
        bValid_q <= 1'b0;
        awReady_q <= 1'b1;
        wReady_q <= 1'b1;
      end
    end
  end

  // read mux of the byte-wide register file
  always_comb
  begin
    readByte = ZERO_RST;
    case (rIdx)
      IDX_POL_INV: readByte = polInv_q;
      IDX_EQ_LO: readByte = eqLo_q;
      IDX_EQ_HI: readByte = eqHi_q;
      IDX_LB_EN: readByte = lbEn_q;
      IDX_LB_CTL: readByte = lbCtl_q;
      IDX_LINK_PAGE: readByte = linkPage_q;
      IDX_SYNC_DUR: readByte = syncDur_q;
      IDX_CGS_STAT: readByte = cgsStat_q;
      IDX_ILAS_STAT: readByte = ilasStat_q;
      IDX_QUAL: readByte = qual_q;
      IDX_TEST_MODE: readByte = testMode_q;
      IDX_THRESH: readByte = thresh_q;
      IDX_MASK: readByte = mask_q;
      IDX_IRQ_EN: readByte = irqEn_q;
      IDX_IRQ_EN_MM: readByte = irqEnMm_q;
      IDX_IRQ_ST: readByte = irqSt_q;
      IDX_IRQ_ST_MM: readByte = irqStMm_q;
      default:
      begin
        for (int i = 0; i < LANES; i++)
        begin
          if (rIdx == IDX_ERR_CTRL + 11'(i))
            readByte = errCtrl_q[i];
          if (rIdx == IDX_HOLD + 11'(i))
            readByte = hold_q[i];
          if (rIdx == IDX_TERM + 11'(i))
            readByte = {4'h0, active_q[i], laneTerm[i]};
          for (int t = 0; t < 3; t++)
          begin
            if (rIdx == IDX_COUNT + 11'(i * 4 + t))
              readByte = laneCount[i][t*8 +: 8];
          end
        end
      end
    endcase
  end

  // axi read channel; unmapped reads answer slverr with zero data
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rData_q <= 32'h00000000;
      rResp_q <= RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (arvalid && arReady_q)
      begin
        arReady_q <= 1'b0;
        rValid_q <= 1'b1;
        rData_q <= {24'h000000, readByte};
        rResp_q <= isMapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rValid_q && rready)
      begin
        rValid_q <= 1'b0;
        arReady_q <= 1'b1;
      end
    end
  end

  // software written configuration
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      polInv_q <= ZERO_RST;
      eqLo_q <= ZERO_RST;
      eqHi_q <= ZERO_RST;
      lbEn_q <= ZERO_RST;
      lbCtl_q <= ZERO_RST;
      linkPage_q <= ZERO_RST;
      syncDur_q <= ZERO_RST;
      qual_q <= ZERO_RST;
      testMode_q <= ZERO_RST;
      thresh_q <= THRESH_RST;
      mask_q <= MASK_RST;
      irqEn_q <= ZERO_RST;
      irqEnMm_q <= ZERO_RST;
      for (int i = 0; i < LANES; i++)
      begin
        errCtrl_q[i] <= ERR_CTRL_RST;
        hold_q[i] <= ZERO_RST;
      end
    end
    else if (clkEn && wr)
    begin
      case (awIdx_q)
        IDX_POL_INV: polInv_q <= wData_q;
        IDX_EQ_LO: eqLo_q <= wData_q;
        IDX_EQ_HI: eqHi_q <= wData_q;
        IDX_LB_EN: lbEn_q <= wData_q;
        IDX_LB_CTL: lbCtl_q <= {6'h00, wData_q[1:0]};
        IDX_LINK_PAGE: linkPage_q <= wData_q;
        IDX_SYNC_DUR: syncDur_q <= wData_q;
        IDX_QUAL: qual_q <= wData_q;
        IDX_TEST_MODE: testMode_q <= wData_q;
        IDX_THRESH: thresh_q <= wData_q;
        IDX_MASK:
        begin
          if (linkPage_q[LINK_PAGE_BIT])
            mask_q <= {5'h00, wData_q[2:0]};
        end
        IDX_IRQ_EN: irqEn_q <= wData_q;
        IDX_IRQ_EN_MM: irqEnMm_q <= {7'h00, wData_q[0]};
        default:
        begin
          for (int i = 0; i < LANES; i++)
          begin
            if (awIdx_q == IDX_ERR_CTRL + 11'(i))
              errCtrl_q[i] <= {2'h0, wData_q[5:0]};
            if (awIdx_q == IDX_HOLD + 11'(i))
              hold_q[i] <= {5'h00, wData_q[2:0]};
          end
        end
      endcase
    end
  end

  // link status capture and interrupt status; a new event beats a clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cgsStat_q <= ZERO_RST;
      ilasStat_q <= ZERO_RST;
      active_q <= ZERO_RST;
      irqSt_q <= ZERO_RST;
      irqStMm_q <= ZERO_RST;
      thrPrev_q <= 3'h0;
    end
    else if (clkEn)
    begin
      cgsStat_q <= cgsDone;
      ilasStat_q <= ilasDone;
      active_q <= laneActive;
      thrPrev_q <= thrAny;
      // link reinit does not touch these bits
      irqSt_q <= (irqSt_q & ~((wr && awIdx_q == IDX_IRQ_ST) ?
        wData_q : ZERO_RST)) | (irqEn_q & {thrAny & ~thrPrev_q,
        linkFailEvent});
      irqStMm_q <= (irqStMm_q & ~((wr && awIdx_q == IDX_IRQ_ST_MM) ?
        wData_q : ZERO_RST)) | {7'h00, irqEnMm_q[0] && configMismatch};
    end
  end

  // sync request sequencer with programmable error pulse
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      pulseCnt_q <= 5'h00;
      syncN_q <= 1'b1;
    end
    else if (clkEn)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (linkEnable)
            state_q <= ST_CGS;
        end
        ST_CGS:
        begin
          if (!linkEnable)
            state_q <= ST_IDLE;
          else if (cgsAll)
            state_q <= ST_DATA;
        end
        ST_DATA:
        begin
          if (!linkEnable)
            state_q <= ST_IDLE;
          else if (errAny)
          begin
            state_q <= ST_PULSE;
            pulseCnt_q <= pulseClks(syncDur_q[DUR_LSB +: 4]);
          end
        end
        ST_PULSE:
        begin
          pulseCnt_q <= pulseCnt_q - 5'h01;
          if (!linkEnable)
            state_q <= ST_IDLE;
          else if (pulseCnt_q <= 5'h01)
            state_q <= ST_DATA;
        end
        default: state_q <= ST_IDLE;
      endcase
      // request stays low while idle, in cgs, in a pulse or at threshold of a type whose mask bit is set
      syncN_q <= (state_q == ST_DATA) && !(|thrSync);
    end
  end

  // prbs7 loopback source; sync init falling edge reseeds it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prbs_q <= PRBS_SEED;
      halfPhase_q <= 1'b0;
      syncInitPrev_q <= 1'b0;
      lbData_q <= ZERO_RST;
    end
    else if (clkEn)
    begin
      syncInitPrev_q <= lbCtl_q[LB_SYNC_BIT];
      halfPhase_q <= !halfPhase_q;
      if (syncInitPrev_q && !lbCtl_q[LB_SYNC_BIT])
      begin
        prbs_q <= PRBS_SEED;
        halfPhase_q <= 1'b0;
      end
      else if (!lbCtl_q[LB_HALF_BIT] || halfPhase_q)
        prbs_q <= {prbs_q[5:0], prbs_q[6] ^ prbs_q[5]};
      lbData_q <= lbEn_q & {LANES{prbs_q[6]}};
    end
  end

  assign awready = awReady_q;
  assign wready = wReady_q;
  assign bvalid = bValid_q;
  assign bresp = bResp_q;
  assign arready = arReady_q;
  assign rvalid = rValid_q;
  assign rdata = rData_q;
  assign rresp = rResp_q;
  assign syncRequestOutN = syncN_q;
  assign loopbackData = lbData_q;
  assign loopbackLaneEnable = lbEn_q;
  assign loopbackHalfRate = lbCtl_q[LB_HALF_BIT];
  assign equalizerGainField = {eqHi_q, eqLo_q};
  assign laneInvertSelect = polInv_q;
  assign ilasTestMode = testMode_q[ILAS_TEST_BIT];
  assign readErrorQualify = qual_q[QUAL_BIT];
endmodule : sem_monitor
`default_nettype wire

/* File: logic/sem_pkg.sv */
// constants and types shared by the serial link error monitor
package sem_pkg;
  localparam int LANES = 8;
  localparam int ADDR_W = 13;
  typedef logic [10:0] sem_idx_type;

  // register indices; byte address is four times the index
  localparam sem_idx_type IDX_POL_INV = 11'h234;
  localparam sem_idx_type IDX_EQ_LO = 11'h240;
  localparam sem_idx_type IDX_EQ_HI = 11'h241;
  localparam sem_idx_type IDX_LB_EN = 11'h250;
  localparam sem_idx_type IDX_LB_CTL = 11'h251;
  localparam sem_idx_type IDX_LINK_PAGE = 11'h300;
  localparam sem_idx_type IDX_SYNC_DUR = 11'h312;
  localparam sem_idx_type IDX_CGS_STAT = 11'h470;
  localparam sem_idx_type IDX_ILAS_STAT = 11'h473;
  localparam sem_idx_type IDX_QUAL = 11'h476;
  localparam sem_idx_type IDX_TEST_MODE = 11'h477;
  localparam sem_idx_type IDX_THRESH = 11'h47C;
  localparam sem_idx_type IDX_MASK = 11'h47D;
  localparam sem_idx_type IDX_ERR_CTRL = 11'h480;
  localparam sem_idx_type IDX_HOLD = 11'h488;
  localparam sem_idx_type IDX_TERM = 11'h490;
  localparam sem_idx_type IDX_TERM_LAST = 11'h497;
  localparam sem_idx_type IDX_IRQ_EN = 11'h4B8;
  localparam sem_idx_type IDX_IRQ_EN_MM = 11'h4B9;
  localparam sem_idx_type IDX_IRQ_ST = 11'h4BA;
  localparam sem_idx_type IDX_IRQ_ST_MM = 11'h4BB;
  localparam sem_idx_type IDX_COUNT = 11'h4C0;
  localparam sem_idx_type IDX_COUNT_SPAN = 11'h020;

  // field positions; error type order is 0 unexpected, 1 nit, 2 disparity
  localparam int LB_SYNC_BIT = 0;
  localparam int LB_HALF_BIT = 1;
  localparam int LINK_PAGE_BIT = 2;
  localparam int DUR_LSB = 4;
  localparam int QUAL_BIT = 4;
  localparam int ILAS_TEST_BIT = 7;
  localparam int ERR_EN_LSB = 3;
  localparam int CNT_RST_LSB = 0;
  localparam int ACTIVE_BIT = 3;
  localparam int IRQ_ERR_LSB = 5;
  localparam int TYPE_UEK = 0;
  localparam int TYPE_NIT = 1;
  localparam int TYPE_BDE = 2;

  // reset values
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'hFF;
  localparam logic [7:0] MASK_RST = 8'h07;
  localparam logic [7:0] ERR_CTRL_RST = 8'h38;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [6:0] PRBS_SEED = 7'h7F;

  // timing: one parallel clock spans two clk cycles
  localparam logic [4:0] PCLK_CLKS = 5'h02;
  localparam logic [4:0] HALF_PCLK_CLKS = 5'h01;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sync request sequencer, gray coded along idle-cgs-data-pulse
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CGS = 2'h1,
    ST_DATA = 2'h3,
    ST_PULSE = 2'h2
  } sem_sync_state_type;
endpackage : sem_pkg

/* File: logic/sem_cnt_if.sv */
// per-lane link between the monitor and its error counters
`timescale 1ns/100ps
`default_nettype none
interface sem_cnt_if;
  logic [2:0] errIn;
  logic [2:0] enable;
  logic [2:0] clear;
  logic [2:0] hold;
  logic [7:0] threshold;
  wire [23:0] count;
  wire [2:0] terminal;
  wire [2:0] atThreshold;
  modport ctl (output errIn, enable, clear, hold, threshold,
    input count, terminal, atThreshold);
  modport cnt (input errIn, enable, clear, hold, threshold,
    output count, terminal, atThreshold);
endinterface : sem_cnt_if
`default_nettype wire

/* File: logic/sem_lane_counter.sv */
// three eight-bit error counters of one lane
`timescale 1ns/100ps
`default_nettype none
module sem_lane_counter
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  sem_cnt_if.cnt port
);
  import sem_pkg::*;

  genvar t;
  generate
    for (t = 0; t < 3; t++)
    begin : g_type
      logic [7:0] count_q;
      logic terminal_q;
      // count enabled errors, saturate or wrap as the hold flag says
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          count_q <= ZERO_RST;
        end
        else if (clkEn)
        begin
          if (port.clear[t])
          begin
            count_q <= ZERO_RST;
          end
          else if (port.enable[t] && port.errIn[t])
          begin
            if (!(port.hold[t] && count_q == CNT_MAX))
            begin
              count_q <= count_q + 8'h01;
            end
          end
        end
      end
      // sticky terminal flag, dropped only with the counter reset
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          terminal_q <= 1'b0;
        end
        else if (clkEn)
        begin
          if (port.clear[t])
          begin
            terminal_q <= 1'b0;
          end
          else if (count_q == CNT_MAX)
          begin
            terminal_q <= 1'b1;
          end
        end
      end
      assign port.count[t*8 +: 8] = count_q;
      assign port.terminal[t] = terminal_q;
      assign port.atThreshold[t] = (count_q == port.threshold);
    end
  endgenerate
endmodule : sem_lane_counter
`default_nettype wire

/* File: logic/sem_lane_counter_note.sv */
// intentionally empty companion: no logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: tb/sem_monitor_asserts.sv */
// bus handshake and output checks for the serial link error monitor
`timescale 1ns/100ps
`default_nettype none
module sem_monitor_asserts
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic linkEnable,
  input wire logic syncRequestOutN,
  input wire logic [7:0] loopbackData,
  input wire logic [7:0] loopbackLaneEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // answers stand until taken, and come at the promised edge
  AST_B_STANDS:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  AST_W_ANSWER:
    assert property (awvalid && awready && wvalid && wready && clkEn
      |=> ##1 bvalid)
    else $error("write response late");
  AST_AR_ANSWER:
    assert property (arvalid && arready && clkEn |=> rvalid)
    else $error("read data late");
  AST_R_STANDS:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  AST_R_SHAPE:
    assert property (rvalid |-> rdata[31:8] == 24'h000000 && !arready)
    else $error("read data upper bits or ready wrong");
  AST_B_BLOCK:
    assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  // lag of two cycles covers the registered data path
  AST_LB_OFF:
    assert property ($stable(loopbackLaneEnable) ##1
      $stable(loopbackLaneEnable)
      |-> (loopbackData & ~loopbackLaneEnable) == 8'h00)
    else $error("loopback data on disabled lane");
  // rstn skips the release edge; three samples cover the registered lag
  AST_IDLE_REQ:
    assert property (rstn && !linkEnable ##1 !linkEnable ##1 !linkEnable
      |-> !syncRequestOutN)
    else $error("sync released before link enable");
endmodule : sem_monitor_asserts
`default_nettype wire

/* File: tb/sem_tx_model.sv */
// transmitter stand-in: code groups on link enable, then lane alignment
`timescale 1ns/100ps
`default_nettype none
module sem_tx_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic linkEnable,
  input wire logic syncN,
  input wire logic [7:0] lanes,
  output logic [7:0] cgsDone,
  output logic [7:0] ilasDone
);
  logic [2:0] kCnt_q;
  logic [2:0] aCnt_q;
  // four code groups per lane, alignment only once sync is released
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      kCnt_q <= 3'h0;
      aCnt_q <= 3'h0;
    end
    else
    begin
      if (linkEnable && kCnt_q != 3'h4)
        kCnt_q <= kCnt_q + 3'h1;
      if (syncN && kCnt_q == 3'h4 && aCnt_q != 3'h4)
        aCnt_q <= aCnt_q + 3'h1;
    end
  end
  assign cgsDone = (kCnt_q == 3'h4) ? lanes : 8'h00;
  assign ilasDone = (aCnt_q == 3'h4) ? lanes : 8'h00;
endmodule : sem_tx_model
`default_nettype wire

/* File: tb/tb_sem_monitor.sv */
// self-checking bench for the serial link error monitor
`timescale 1ns/100ps
`default_nettype none
module tb_sem_monitor;
  import sem_pkg::*;
  logic clk, rstn, awvalid, awready, wvalid, wready, bready, bvalid;
  logic arvalid, arready, rvalid, rready, linkEnable, linkReinit, syncN;
  logic [12:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, rr;
  logic [4:0] failEv;
  logic [7:0] lanes, cgs, ilas, lbData, lbEn;
  wire [26:0] cfg; // {half rate, gain, invert, ilas mode, qualify}
  logic [23:0] errs;
  int num_errors, checks, n;
  sem_monitor dut (.clk(clk), .rstn(rstn), .clkEn(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .linkEnable(linkEnable), .linkReinit(linkReinit), .laneEnabled(lanes),
    .laneActive(lanes), .cgsDone(cgs), .ilasDone(ilas),
    .linkFailEvent(failEv), .configMismatch(1'b0),
    .unexpectedControlChar(errs[7:0]), .notInTable(errs[15:8]),
    .badDisparity(errs[23:16]), .syncRequestOutN(syncN),
    .loopbackData(lbData), .loopbackLaneEnable(lbEn),
    .loopbackHalfRate(cfg[26]), .equalizerGainField(cfg[25:10]),
    .laneInvertSelect(cfg[9:2]), .ilasTestMode(cfg[1]),
    .readErrorQualify(cfg[0]));
  sem_tx_model tx (.clk(clk), .rstn(rstn), .linkEnable(linkEnable),
    .syncN(syncN), .lanes(lanes), .cgsDone(cgs), .ilasDone(ilas));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // no wait limit here: the watchdog cuts a hung handshake
  task automatic wr(input sem_idx_type i, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input sem_idx_type i);
    @(posedge clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rc(input sem_idx_type i, input logic [7:0] e);
    rd(i);
    chk($sformatf("reg %h", i), {24'h000000, e}, rv);
  endtask : rc
  // errs holds {disparity, nit, unexpected}, one bit per lane
  task automatic hit(input int cnt, input logic [23:0] e);
    repeat (cnt)
    begin
      @(posedge clk);
      errs <= e;
    end
    @(posedge clk);
    errs <= 24'h000000;
  endtask : hit
  // watchdog, far beyond the several hundred cycles the tests need
  initial
  begin
    #2000000;
    num_errors++;
    close_out();
  end
  // main sequence
  initial
  begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {linkEnable, linkReinit, failEv, errs} = 31'h0;
    {awaddr, araddr, wdata} = 58'h0;
    lanes = 8'h0F;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rc(IDX_THRESH, 8'hFF);
    rc(IDX_MASK, 8'h07);
    rc(IDX_ERR_CTRL + 11'h007, 8'h38);
    rc(IDX_IRQ_EN, 8'h00);
    rc(IDX_IRQ_EN_MM, 8'h00);
    rd(11'h100);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    wr(IDX_MASK, 8'h00);
    rc(IDX_MASK, 8'h07);
    wr(IDX_LINK_PAGE, 8'h04);
    wr(IDX_MASK, 8'h00);
    rc(IDX_MASK, 8'h00);
    wr(IDX_QUAL, 8'h10);
    hit(3, 24'h010100);
    hit(1, 24'h010000);
    rc(IDX_COUNT + 11'h001, 8'h03);
    rc(IDX_COUNT + 11'h002, 8'h01);
    rc(IDX_TERM, 8'h08);
    wr(IDX_HOLD + 11'h001, 8'h02);
    hit(257, 24'h000200);
    rc(IDX_COUNT + 11'h005, 8'hFF);
    rc(IDX_TERM + 11'h001, 8'h0A);
    wr(IDX_ERR_CTRL + 11'h001, 8'h3A);
    wr(IDX_ERR_CTRL + 11'h001, 8'h38);
    rc(IDX_COUNT + 11'h005, 8'h00);
    hit(257, 24'h000400);
    rc(IDX_COUNT + 11'h009, 8'h01);
    wr(IDX_ERR_CTRL + 11'h004, 8'h30);
    hit(2, 24'h000010);
    rc(IDX_COUNT + 11'h010, 8'h00);
    wr(IDX_THRESH, 8'h02);
    wr(IDX_IRQ_EN, 8'hE1);
    hit(2, 24'h000008);
    @(posedge clk);
    failEv <= 5'h01;
    @(posedge clk);
    failEv <= 5'h00;
    rc(IDX_IRQ_ST, 8'h21);
    wr(IDX_IRQ_ST, 8'h20);
    rc(IDX_IRQ_ST, 8'h01);
    @(posedge clk);
    linkReinit <= 1'b1;
    @(posedge clk);
    linkReinit <= 1'b0;
    rc(IDX_COUNT + 11'h00C, 8'h00);
    rc(IDX_IRQ_ST, 8'h01);
    wr(IDX_POL_INV, 8'h00);
    wr(IDX_LB_EN, 8'h05);
    chk("loopback lanes", 32'h05, {24'h0, lbEn});
    wr(IDX_TEST_MODE, 8'h80);
    wr(IDX_LB_CTL, 8'h03);
    wr(IDX_LB_CTL, 8'h02);
    // the reseed lands one edge after the write, the data one edge later
    repeat (2) @(posedge clk);
    chk("loopback data", 32'h05, {24'h0, lbData});
    chk("config pins", 32'h04000003, {5'h00, cfg});
    @(posedge clk);
    linkEnable <= 1'b1;
    do
      @(posedge clk);
    while (syncN !== 1'b1);
    rc(IDX_CGS_STAT, 8'h0F);
    repeat (6) @(posedge clk);
    rc(IDX_ILAS_STAT, 8'h0F);
    chk("sync held", 32'h1, {31'h0, syncN});
    for (int d = 0; d < 3; d++)
    begin
      wr(IDX_SYNC_DUR, 8'(d * 16));
      hit(1, 24'h000001);
      n = 0;
      repeat (12)
      begin
        @(posedge clk);
        n += (syncN === 1'b0);
      end
      chk("pulse width", (d == 0) ? 1 : 2 * d, n);
    end
    close_out();
  end
endmodule : tb_sem_monitor
bind sem_monitor sem_monitor_asserts sva (.clk(clk), .rstn(rstn),
  .clkEn(clkEn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .rready(rready), .linkEnable(linkEnable),
  .syncRequestOutN(syncRequestOutN), .loopbackData(loopbackData),
  .loopbackLaneEnable(loopbackLaneEnable));
`default_nettype wire
